// ==== link_ctrl_pkg.sv ====
// Package for the link control field outputs block: offsets, field positions,
// reset values. Assumes a 32-bit classic Wishbone bus with byte addresses.
// Overview of operation
// - Bandwidth interrupt enable out, bit 10, active low
// - Clock PM enable out follows bit 8
// - Common refclk config out follows bit 6
// - Extended sync out follows bit 7
package link_ctrl_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam int          LCTRL_W         = 16;
  localparam logic [3:0]  OFS_LINK_CTRL   = 4'h0;  // link_control_register
  localparam logic [3:0]  OFS_FIELD_STAT  = 4'h4;  // Live state of the four outputs
  localparam int          BIT_CLK_PM      = 8;
  localparam int          BIT_COMMON_CLK  = 6;
  localparam int          BIT_EXT_SYNC    = 7;
  localparam int          BIT_BW_IRQ_EN   = 10;
  localparam logic [15:0] LCTRL_RESET     = 16'h0000;
  localparam logic [15:0] LCTRL_WR_MASK   = 16'h0FDB;  // Bits 15:12, 5 and 2 read zero
  localparam int          STAT_BW         = 0;
  localparam int          STAT_CLK_PM     = 1;
  localparam int          STAT_COMMON     = 2;
  localparam int          STAT_EXT_SYNC   = 3;
endpackage

// ==== link_control_field_outputs.sv ====
// Link control register with four fields presented as user-clock outputs.
// Assumes a classic Wishbone master on the same clock and a synchronous reset.
// The block only reports the four settings; it raises no interrupt and drives
// no clock request itself, so the fabric logic must act on the outputs.
// Every bus access is answered one cycle after it is taken. The master must
// drop cyc and stb for a cycle after each ack before its next request.
// Unmapped offsets answer with ack and read zero, so a stray access never hangs.
// Bits outside the writable mask always read zero and never reach an output.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module link_control_field_outputs (
  input  wire logic                            clk_i,                       // User clock, 20 MHz
  input  wire logic                            rst_i,                       // Sync reset, active high
  input  wire logic                            cyc_i,                       // Wishbone cycle
  input  wire logic                            stb_i,                       // Wishbone strobe
  input  wire logic                            we_i,                        // Write enable
  input  wire logic [link_ctrl_pkg::ADDR_W-1:0] adr_i,                      // Byte address
  input  wire logic [3:0]                      sel_i,                       // Byte lanes
  input  wire logic [link_ctrl_pkg::DATA_W-1:0] dat_i,                      // Write data
  output logic      [link_ctrl_pkg::DATA_W-1:0] dat_o,                      // Read data
  output logic                                 ack_o,                       // Acknowledge
  output logic                                 bw_mgmt_irq_enable_out_o,    // Low = enabled
  output logic                                 clock_pm_enable_out_o,       // Clock request allowed
  output logic                                 common_refclk_config_out_o,  // Shared refclk
  output logic                                 extended_sync_out_o          // Extra ordered sets
);
  import link_ctrl_pkg::*;

  logic [LCTRL_W-1:0] lctrl_ff, nxt_lctrl;
  logic [DATA_W-1:0]  rdata_ff, nxt_rdata;
  logic               ack_ff, nxt_ack;
  logic               bw_ff, nxt_bw;
  logic               cpm_ff, nxt_cpm;
  logic               ccc_ff, nxt_ccc;
  logic               esync_ff, nxt_esync;
  logic               req, wr_take;

  // Expand two byte selects into a 16-bit lane mask
  function automatic logic [LCTRL_W-1:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Write lands on the same edge the master sees ack, as classic cycles require
  assign req     = cyc_i & stb_i;
  assign wr_take = req & ack_ff & we_i;

  // Register file and bus answer; every access answers one cycle after request
  always_comb begin
    nxt_ack   = req & ~ack_ff;
    nxt_lctrl = lctrl_ff;
    nxt_rdata = '0;
    if (wr_take && adr_i == OFS_LINK_CTRL) begin
      nxt_lctrl = (lctrl_ff & ~(lane_mask(sel_i) & LCTRL_WR_MASK))
                | (dat_i[LCTRL_W-1:0] & lane_mask(sel_i) & LCTRL_WR_MASK);
    end
    if (req && !ack_ff && !we_i) begin
      case (adr_i)
        OFS_LINK_CTRL:  nxt_rdata = {{(DATA_W-LCTRL_W){1'b0}}, lctrl_ff};
        OFS_FIELD_STAT: begin
          nxt_rdata[STAT_BW]       = bw_ff;
          nxt_rdata[STAT_CLK_PM]   = cpm_ff;
          nxt_rdata[STAT_COMMON]   = ccc_ff;
          nxt_rdata[STAT_EXT_SYNC] = esync_ff;
        end
        default:        nxt_rdata = '0;  // Unmapped reads answer zero
      endcase
    end
  end

  // Outputs are flops fed from the next register value, so they move on the same edge as the register write
  always_comb begin
    nxt_bw    = ~nxt_lctrl[BIT_BW_IRQ_EN];
    nxt_cpm   = nxt_lctrl[BIT_CLK_PM];
    nxt_ccc   = nxt_lctrl[BIT_COMMON_CLK];
    nxt_esync = nxt_lctrl[BIT_EXT_SYNC];
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lctrl_ff <= LCTRL_RESET;
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
      bw_ff    <= ~LCTRL_RESET[BIT_BW_IRQ_EN];
      cpm_ff   <= LCTRL_RESET[BIT_CLK_PM];
      ccc_ff   <= LCTRL_RESET[BIT_COMMON_CLK];
      esync_ff <= LCTRL_RESET[BIT_EXT_SYNC];
    end else begin
      lctrl_ff <= nxt_lctrl;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
      bw_ff    <= nxt_bw;
      cpm_ff   <= nxt_cpm;
      ccc_ff   <= nxt_ccc;
      esync_ff <= nxt_esync;
    end
  end

  // Interrupt generation and clock request handling are left to user logic
  assign dat_o                      = rdata_ff;
  assign ack_o                      = ack_ff;
  assign bw_mgmt_irq_enable_out_o   = bw_ff;     // Low means the fabric may interrupt
  assign clock_pm_enable_out_o      = cpm_ff;    // Fabric decides on clock request
  assign common_refclk_config_out_o = ccc_ff;
  assign extended_sync_out_o        = esync_ff;

  // A taken write to the link control word with the high byte enabled
  sequence lctrl_hi_wr_s;
    wr_take && adr_i == OFS_LINK_CTRL && sel_i[1];
  endsequence

  sequence lctrl_lo_wr_s;
    wr_take && adr_i == OFS_LINK_CTRL && sel_i[0];
  endsequence

  bw_irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lctrl_hi_wr_s |=> bw_mgmt_irq_enable_out_o == ~$past(dat_i[BIT_BW_IRQ_EN]))
    else $error("bandwidth irq enable output not inverted bit 10");

  clk_pm_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lctrl_hi_wr_s |=> clock_pm_enable_out_o == $past(dat_i[BIT_CLK_PM]))
    else $error("clock pm enable output not bit 8");

  common_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lctrl_lo_wr_s |=> common_refclk_config_out_o == $past(dat_i[BIT_COMMON_CLK]))
    else $error("common clock output not bit 6");

  ext_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lctrl_lo_wr_s |=> extended_sync_out_o == $past(dat_i[BIT_EXT_SYNC]))
    else $error("extended sync output not bit 7");

  outputs_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_take && adr_i == OFS_LINK_CTRL) |=> $stable(extended_sync_out_o) && $stable(common_refclk_config_out_o)
      && $stable(clock_pm_enable_out_o) && $stable(bw_mgmt_irq_enable_out_o))
    else $error("field output changed without a write");

  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle answer");

  // A read request as the slave takes it; the data stands one edge later
  sequence rd_take_s;
    req && !ack_ff && !we_i;
  endsequence

  // Status read returns the live output levels of the request cycle
  stat_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_take_s ##0 (adr_i == OFS_FIELD_STAT) |=>
      dat_o == {{(DATA_W-4){1'b0}}, $past(extended_sync_out_o), $past(common_refclk_config_out_o),
                $past(clock_pm_enable_out_o), $past(bw_mgmt_irq_enable_out_o)})
    else $error("status read does not match the field outputs");

  // Register read returns the stored word, upper half zero
  lctrl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_take_s ##0 (adr_i == OFS_LINK_CTRL) |=> dat_o == {{(DATA_W-LCTRL_W){1'b0}}, $past(lctrl_ff)})
    else $error("link control read does not match the stored word");

  // Unmapped reads must answer zero so software sees no stale data
  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_take_s ##0 (adr_i != OFS_LINK_CTRL && adr_i != OFS_FIELD_STAT) |=> dat_o == '0)
    else $error("unmapped read not zero");

  // Read data is only meaningful with ack; it idles at zero
  idle_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == '0)
    else $error("read data not zero outside ack");

  // Fixed-zero bits must never be stored, whatever the write data
  fixed_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lctrl_ff & ~LCTRL_WR_MASK) == '0)
    else $error("non-writable link control bit set");

  // Each output mirrors its stored bit at all times outside reset; the bandwidth output is the inverse of bit 10
  bw_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bw_mgmt_irq_enable_out_o == ~lctrl_ff[BIT_BW_IRQ_EN])
    else $error("bandwidth irq enable output not inverse of stored bit");

  cpm_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_pm_enable_out_o == lctrl_ff[BIT_CLK_PM])
    else $error("clock pm enable output differs from stored bit");

  ccc_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
    common_refclk_config_out_o == lctrl_ff[BIT_COMMON_CLK])
    else $error("common clock output differs from stored bit");

  esync_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
    extended_sync_out_o == lctrl_ff[BIT_EXT_SYNC])
    else $error("extended sync output differs from stored bit");

  // Reset must leave the bus quiet and the register at its reset word
  reset_state_a: assert property (@(posedge clk_i)
    rst_i |=> !ack_o && dat_o == '0 && lctrl_ff == LCTRL_RESET && bw_mgmt_irq_enable_out_o)
    else $error("reset did not restore the idle state");
endmodule

// ==== app_model.sv ====
// Fabric logic acting on the reported link control fields.
// Assumes the field outputs come from the block on the user clock.
`timescale 1ns/1ps
module app_model (
  input  wire logic bw_en_n_i,   // Low = interrupt enabled
  input  wire logic bw_sts_i,    // Bandwidth status
  input  wire logic pm_en_i,     // Clock request allowed
  output logic      irq_o,       // Fabric interrupt
  output logic      clkreq_o     // Clock request
);
  // The block only reports the enables, so the fabric makes both functions
  assign irq_o = bw_sts_i & ~bw_en_n_i;
  assign clkreq_o = pm_en_i;
endmodule

// ==== tb_link_control_field_outputs.sv ====
// Random bench for the link control field outputs block.
// Assumes one user clock and the app_model partner on the outputs.
`timescale 1ns/1ps
module tb_link_control_field_outputs;
  import link_ctrl_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bws = 0, ack, bw, pm, cc, es, irq, ckr;
  logic [3:0]  adr = 4'h0, sel = 4'h0, s;
  logic [31:0] dat = 32'h0, dat_o, q, d, lf = 32'hCA7640A7;
  logic [15:0] ex = 16'h0000;
  int          err_total = 0, check_count = 0;
  always #25 clk_i = ~clk_i;
  link_control_field_outputs u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .bw_mgmt_irq_enable_out_o(bw),
    .clock_pm_enable_out_o(pm), .common_refclk_config_out_o(cc), .extended_sync_out_o(es));
  app_model u_app (.bw_en_n_i(bw), .bw_sts_i(bws), .pm_en_i(pm), .irq_o(irq), .clkreq_o(ckr));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Lane-masked expected value; fixed-zero bits never stick
  function automatic logic [15:0] upd(input logic [15:0] o, input logic [31:0] v, input logic [3:0] m);
    logic [15:0] k;
    k = {{8{m[1]}}, {8{m[0]}}};
    return ((o & ~k) | (v[15:0] & k)) & LCTRL_WR_MASK;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One classic cycle, held until ack is sampled; a hung slave is counted
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v, input logic [3:0] m);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, v, m};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  initial begin
    #200000 err_total++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({es, cc, pm, bw}, 4'h1);
    for (int i = 0; i < 150; i++) begin
      lf = step(lf);
      d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : lf;
      s = (i < 2) ? 4'hF : lf[27:24];
      wb(1'b1, OFS_LINK_CTRL, d, s);
      ex = upd(ex, d, s);
      bws <= lf[9];
      check({es, cc, pm, bw}, {ex[7], ex[6], ex[8], ~ex[10]});
      wb(1'b0, OFS_LINK_CTRL, lf, 4'hF);
      check(q, {16'h0, ex});
      check({irq, ckr}, {lf[9] & ex[10], ex[8]});
      wb(1'b0, OFS_FIELD_STAT, lf, 4'hF);
      check(q, {ex[7], ex[6], ex[8], ~ex[10]});
    end
    $display("test random writes done");
    wb(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 4'hC, 32'h0, 4'hF);
    check(q, 32'h0);
    check({es, cc, pm, bw}, {ex[7], ex[6], ex[8], ~ex[10]});
    $display("test unmapped done");
    conclude();
  end
endmodule
